// ===== shared/tap_pkg.sv
// shared constants and types for the boundary-scan port and its tester end
package tap_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TCK_PERIOD_NS = 160;
  localparam int TCK_HALF      = TCK_PERIOD_NS / CLK_PERIOD_NS / 2;

  // ---------------------------------------------------------------
  // widths and sizes
  // ---------------------------------------------------------------
  localparam int IR_LEN     = 4;
  localparam int ID_LEN     = 32;
  localparam int N_PINS     = 4;
  localparam int CHAIN_LEN  = 2 * N_PINS;
  localparam int WORD_W     = 32;
  localparam int LEN_W      = 6;
  localparam int FIFO_DEPTH = 16;
  localparam int RESET_HIGHS = 5;

  // ---------------------------------------------------------------
  // instruction codes, capture and reset values
  // ---------------------------------------------------------------
  localparam logic [IR_LEN-1:0] OP_EXTEST  = 4'h0;
  localparam logic [IR_LEN-1:0] OP_SAMPLE  = 4'h1;
  localparam logic [IR_LEN-1:0] OP_IDCODE  = 4'h2;
  localparam logic [IR_LEN-1:0] OP_CLAMP   = 4'h3;
  localparam logic [IR_LEN-1:0] OP_HIGHZ   = 4'h4;
  localparam logic [IR_LEN-1:0] OP_BYPASS  = 4'hF;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_LEN-1:0] IR_RESET   = OP_IDCODE;

  // ---------------------------------------------------------------
  // host tms sequences, lsb sent first
  // ---------------------------------------------------------------
  localparam logic [5:0] SEQ_RESET = 6'h1F;
  localparam logic [5:0] SEQ_DR    = 6'h01;
  localparam logic [5:0] SEQ_IR    = 6'h03;
  localparam logic [LEN_W-1:0] SEQ_RESET_LEN = 6'h06;
  localparam logic [LEN_W-1:0] SEQ_DR_LEN    = 6'h03;
  localparam logic [LEN_W-1:0] SEQ_IR_LEN    = 6'h04;
  localparam logic [LEN_W-1:0] TAIL_LEN      = 6'h02;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    TLR, RTI,
    SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;

  typedef enum logic [1:0] {DR_PASS, DR_ID, DR_CHAIN} dr_sel_t;

  typedef enum logic [1:0] {CMD_RESET, CMD_IR, CMD_DR} cmd_kind_t;

endpackage : tap_pkg

// ===== shared/tap_if.sv
// test access port wires between tester and device
`timescale 1ns/1ns
interface tap_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  logic tdo_line;

  // pulled high when the device releases tdo
  assign tdo_line = tdo_oe_n ? 1'b1 : tdo;

  modport device (input tck, input tms, input tdi, output tdo, output tdo_oe_n);
  modport host   (output tck, output tms, output tdi, input tdo_line);
endinterface : tap_if

// ===== core/tap_device.sv
// boundary-scan test access port, device end
`timescale 1ns/1ns
module tap_device
  import tap_pkg::*;
#(
  parameter logic [3:0]  ID_VERSION = 4'h1,    // arbitrary value
  parameter logic [15:0] ID_PART    = 16'h1234, // arbitrary value
  parameter logic [10:0] ID_MAKER   = 11'h055   // arbitrary value
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // test port
  tap_if.device                  tap,
  // functional side
  input  wire logic [N_PINS-1:0] core_out,
  input  wire logic [N_PINS-1:0] core_oe_n,
  // pads
  input  wire logic [N_PINS-1:0] pin_in,
  output logic      [N_PINS-1:0] pin_out,
  output logic      [N_PINS-1:0] pin_oe_n
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic dr_sel_t decode_sel(input logic [IR_LEN-1:0] op);
    unique case (op)
      OP_EXTEST, OP_SAMPLE: decode_sel = DR_CHAIN;
      OP_IDCODE:            decode_sel = DR_ID;
      default:              decode_sel = DR_PASS;
    endcase
  endfunction : decode_sel

  function automatic tap_state_t next_of(input tap_state_t s, input logic m);
    unique case (s)
      TLR:    next_of = m ? TLR    : RTI;
      RTI:    next_of = m ? SEL_DR : RTI;
      SEL_DR: next_of = m ? SEL_IR : CAP_DR;
      CAP_DR: next_of = m ? EX1_DR : SH_DR;
      SH_DR:  next_of = m ? EX1_DR : SH_DR;
      EX1_DR: next_of = m ? UPD_DR : PAU_DR;
      PAU_DR: next_of = m ? EX2_DR : PAU_DR;
      EX2_DR: next_of = m ? UPD_DR : SH_DR;
      UPD_DR: next_of = m ? SEL_DR : RTI;
      SEL_IR: next_of = m ? TLR    : CAP_IR;
      CAP_IR: next_of = m ? EX1_IR : SH_IR;
      SH_IR:  next_of = m ? EX1_IR : SH_IR;
      EX1_IR: next_of = m ? UPD_IR : PAU_IR;
      PAU_IR: next_of = m ? EX2_IR : PAU_IR;
      EX2_IR: next_of = m ? UPD_IR : SH_IR;
      UPD_IR: next_of = m ? SEL_DR : RTI;
    endcase
  endfunction : next_of

  // ---------------------------------------------------------------
  // synchronisers and test clock edges
  // ---------------------------------------------------------------
  logic [2:0]        sync1;
  logic [2:0]        sync2;
  logic              tck_q;
  logic [N_PINS-1:0] pin_s1;
  logic [N_PINS-1:0] pin_s2;
  logic              tck_rise;
  logic              tck_fall;
  logic              tms_s;
  logic              tdi_s;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1  <= 3'h0;
      sync2  <= 3'h0;
      tck_q  <= 1'b0;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      sync1  <= {tap.tck, tap.tms, tap.tdi};
      sync2  <= sync1;
      tck_q  <= sync2[2];
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // edges of the test clock pace all shifting, not core_clk
  assign tck_rise = sync2[2] & ~tck_q;
  assign tck_fall = ~sync2[2] & tck_q;
  assign tms_s    = sync2[1];
  assign tdi_s    = sync2[0];

  // ---------------------------------------------------------------
  // port state machine
  // ---------------------------------------------------------------
  tap_state_t state;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= TLR;
    end else if (tck_rise) begin
      state <= next_of(state, tms_s);
    end
  end

  // ---------------------------------------------------------------
  // instruction register
  // ---------------------------------------------------------------
  logic [IR_LEN-1:0] ir_sh;
  logic [IR_LEN-1:0] ir;
  dr_sel_t           sel;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ir_sh <= IR_RESET;
      ir    <= IR_RESET;
    end else if (tck_rise) begin
      unique case (state)
        TLR:     ir    <= IR_RESET;
        CAP_IR:  ir_sh <= IR_CAPTURE;
        SH_IR:   ir_sh <= {tdi_s, ir_sh[IR_LEN-1:1]};
        UPD_IR:  ir    <= ir_sh;
        default: ;
      endcase
    end
  end

  assign sel = decode_sel(ir);

  // ---------------------------------------------------------------
  // data registers
  // ---------------------------------------------------------------
  logic                 pass_bit;
  logic [ID_LEN-1:0]    id_sh;
  logic [CHAIN_LEN-1:0] chain_sh;
  logic [N_PINS-1:0]    upd;
  logic [CHAIN_LEN-1:0] chain_cap;

  // even cell observes the pad, odd cell the value the core drives
  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi++) begin : g_cell
      assign chain_cap[2*gi]   = pin_s2[gi];
      assign chain_cap[2*gi+1] = core_out[gi];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pass_bit <= 1'b0;
      id_sh    <= '0;
      chain_sh <= '0;
    end else if (tck_rise) begin
      if (state == CAP_DR) begin
        pass_bit <= 1'b0;
        id_sh    <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
        chain_sh <= chain_cap;
      end else if (state == SH_DR) begin
        unique case (sel)
          DR_PASS:  pass_bit <= tdi_s;
          DR_ID:    id_sh    <= {tdi_s, id_sh[ID_LEN-1:1]};
          DR_CHAIN: chain_sh <= {tdi_s, chain_sh[CHAIN_LEN-1:1]};
        endcase
      end
    end
  end

  // only the output cells carry an update stage
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      upd <= '0;
    end else if (tck_rise && state == UPD_DR && sel == DR_CHAIN) begin
      for (int i = 0; i < N_PINS; i++) begin
        upd[i] <= chain_sh[2*i+1];
      end
    end
  end

  // ---------------------------------------------------------------
  // tdo, moved on the falling edge
  // ---------------------------------------------------------------
  logic dr_out;

  always_comb begin
    unique case (sel)
      DR_PASS:  dr_out = pass_bit;
      DR_ID:    dr_out = id_sh[0];
      DR_CHAIN: dr_out = chain_sh[0];
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tap.tdo      <= 1'b0;
      tap.tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tap.tdo      <= (state == SH_IR) ? ir_sh[0] : dr_out;
      tap.tdo_oe_n <= !(state == SH_IR || state == SH_DR);
    end
  end

  // ---------------------------------------------------------------
  // pad drive
  // ---------------------------------------------------------------
  logic test_drive;
  logic pads_off;

  // clamp holds the update stage on the pads while bypassing the chain
  assign test_drive = (ir == OP_EXTEST) || (ir == OP_CLAMP);
  assign pads_off   = (ir == OP_HIGHZ);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out  <= test_drive ? upd : core_out;
      pin_oe_n <= pads_off ? '1 : (test_drive ? '0 : core_oe_n);
    end
  end

endmodule : tap_device

// ===== core/tap_host.sv
// boundary-scan tester end with its result buffer
`timescale 1ns/1ns
module tap_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  assign out_valid = (wr_ptr != rd_ptr);
  assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) wr_ptr <= wr_ptr + 1'b1;
      if (out_valid && out_ready) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : tap_fifo

module tap_host
  import tap_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // command
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire cmd_kind_t         cmd_kind,
  input  wire logic [LEN_W-1:0]  cmd_len,
  input  wire logic [WORD_W-1:0] cmd_data,
  // captured words
  output logic                   res_valid,
  input  wire logic              res_ready,
  output logic      [WORD_W-1:0] res_data,
  // test port
  tap_if.host                    tap
);

  typedef enum logic [2:0] {P_IDLE, P_SEQ, P_SHIFT, P_TAIL, P_DONE} phase_t;

  // ---------------------------------------------------------------
  // test clock divider, this end makes the clock
  // ---------------------------------------------------------------
  logic [2:0] div;
  logic       fall_tick;

  assign fall_tick = (div == 3'(2*TCK_HALF-1));

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div     <= 3'h0;
      tap.tck <= 1'b0;
    end else begin
      div <= fall_tick ? 3'h0 : div + 3'h1;
      if (div == 3'(TCK_HALF-1)) tap.tck <= 1'b1;
      if (fall_tick) tap.tck <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // tdo synchroniser
  // ---------------------------------------------------------------
  logic tdo_s1;
  logic tdo_s2;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tdo_s1 <= 1'b1;
      tdo_s2 <= 1'b1;
    end else begin
      tdo_s1 <= tap.tdo_line;
      tdo_s2 <= tdo_s1;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  phase_t            phase;
  logic [5:0]        seq;
  logic [LEN_W-1:0]  cnt;
  logic [LEN_W-1:0]  len;
  logic              is_scan;
  logic [WORD_W-1:0] data;
  logic [WORD_W-1:0] cap;
  logic              was_shift;
  logic              fifo_ready;

  // a command is taken only when its result is sure of a slot
  assign cmd_ready = (phase == P_IDLE) && fifo_ready;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase     <= P_IDLE;
      seq       <= 6'h0;
      cnt       <= '0;
      len       <= '0;
      is_scan   <= 1'b0;
      data      <= '0;
      tap.tms   <= 1'b1;
      tap.tdi   <= 1'b1;
      was_shift <= 1'b0;
    end else begin
      unique case (phase)
        P_IDLE: if (cmd_valid && cmd_ready) begin
          phase   <= P_SEQ;
          is_scan <= (cmd_kind != CMD_RESET);
          len     <= cmd_len;
          data    <= cmd_data;
          unique case (cmd_kind)
            CMD_IR:  begin seq <= SEQ_IR; cnt <= SEQ_IR_LEN; end
            CMD_DR:  begin seq <= SEQ_DR; cnt <= SEQ_DR_LEN; end
            default: begin seq <= SEQ_RESET; cnt <= SEQ_RESET_LEN; end
          endcase
        end else if (fall_tick) begin
          tap.tms   <= 1'b0;
          was_shift <= 1'b0;
        end
        P_SEQ: if (fall_tick) begin
          tap.tms   <= seq[0];
          seq       <= seq >> 1;
          cnt       <= cnt - 6'h1;
          was_shift <= 1'b0;
          if (cnt == 6'h1) begin
            phase <= is_scan ? P_SHIFT : P_IDLE;
            cnt   <= len;
          end
        end
        P_SHIFT: if (fall_tick) begin
          tap.tms   <= (cnt == 6'h1);
          tap.tdi   <= data[0];
          data      <= data >> 1;
          was_shift <= 1'b1;
          cnt       <= cnt - 6'h1;
          if (cnt == 6'h1) begin
            phase <= P_TAIL;
            cnt   <= TAIL_LEN;
          end
        end
        P_TAIL: if (fall_tick) begin
          tap.tms   <= (cnt == TAIL_LEN);
          was_shift <= 1'b0;
          cnt       <= cnt - 6'h1;
          if (cnt == 6'h1) phase <= P_DONE;
        end
        P_DONE: phase <= P_IDLE;
      endcase
    end
  end

  // bit shifted on the last rising edge is read just before the fall
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cap <= '0;
    end else if (fall_tick && was_shift) begin
      cap <= {tdo_s2, cap[WORD_W-1:1]};
    end
  end

  logic [WORD_W-1:0] aligned;
  assign aligned = cap >> (6'd32 - len);

  tap_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .in_valid  (phase == P_DONE),
    .in_ready  (fifo_ready),
    .in_data   (aligned),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

endmodule : tap_host

// ===== sim/tap_checker.sv
// concurrent checks on the wires between tester and device
`timescale 1ns/1ns
module tap_checker
  import tap_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  // --------------------------------
  // reference state walk
  // --------------------------------
  tap_state_t st;
  logic       tck_d;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) tck_d <= 1'b0;
    else tck_d <= tck;
  end

  // runs ahead of the device's synchroniser, so checks allow for its lag
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= TLR;
    end else if (tck && !tck_d) begin
      case (st)
        TLR:     st <= tms ? TLR : RTI;
        RTI:     st <= tms ? SEL_DR : RTI;
        SEL_DR:  st <= tms ? SEL_IR : CAP_DR;
        CAP_DR:  st <= tms ? EX1_DR : SH_DR;
        SH_DR:   st <= tms ? EX1_DR : SH_DR;
        EX1_DR:  st <= tms ? UPD_DR : PAU_DR;
        PAU_DR:  st <= tms ? EX2_DR : PAU_DR;
        EX2_DR:  st <= tms ? UPD_DR : SH_DR;
        SEL_IR:  st <= tms ? TLR : CAP_IR;
        CAP_IR:  st <= tms ? EX1_IR : SH_IR;
        SH_IR:   st <= tms ? EX1_IR : SH_IR;
        EX1_IR:  st <= tms ? UPD_IR : PAU_IR;
        PAU_IR:  st <= tms ? EX2_IR : PAU_IR;
        EX2_IR:  st <= tms ? UPD_IR : SH_IR;
        default: st <= tms ? SEL_DR : RTI;
      endcase
    end
  end

  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence high_run;
    tck [*4] ##1 !tck;
  endsequence
  sequence shift_fall;
    (st == SH_DR || st == SH_IR) && $fell(tck);
  endsequence

  tck_high_a: assert property ($rose(tck) |-> high_run)
    else $error("test clock high phase has wrong length");
  tck_low_a: assert property ($fell(tck) |-> !tck [*4])
    else $error("test clock low phase too short");
  ctl_hold_a: assert property (tck && $past(tck) |-> $stable(tms) && $stable(tdi))
    else $error("mode or data moved while clock high");
  ctl_edge_a: assert property ($changed(tms) || $changed(tdi) |-> !tck)
    else $error("mode or data moved with clock high");
  out_hold_a: assert property (!tdo_oe_n && tck && $past(tck) |-> $stable(tdo))
    else $error("serial out moved while clock high");
  oe_scope_a: assert property (!tdo_oe_n && !tck |->
      st inside {SH_DR, SH_IR, EX1_DR, EX1_IR})
    else $error("serial out driven outside shifting");
  oe_open_a: assert property (shift_fall |-> ##5 !tdo_oe_n)
    else $error("serial out not driven while shifting");
  rst_idle_a: assert property ($rose(resetn) |-> !tck && tdo_oe_n && tms)
    else $error("port not idle after reset");
endmodule : tap_checker

// ===== sim/tb_top.sv
// self-checking bench joining the tester end to the device end
`timescale 1ns/1ns
module tb_top
  import tap_pkg::*;
;
  localparam logic [3:0]  ID_V = 4'h3;     // arbitrary value
  localparam logic [15:0] ID_P = 16'h0A5C; // arbitrary value
  localparam logic [10:0] ID_M = 11'h2B1;  // arbitrary value
  localparam logic [31:0] ID_W = {ID_V, ID_P, ID_M, 1'b1};
  localparam logic [31:0] IRC  = 32'(IR_CAPTURE);

  typedef struct packed {
    cmd_kind_t   k;
    logic [5:0]  n;
    logic [31:0] d;
    logic [31:0] r;
    logic [3:0]  po;
    logic [3:0]  pe;
  } row_t;

  // kind, length, data, word, pin value, pin enable
  row_t rows [15] = '{
    '{CMD_RESET, 6'h00, 32'h0, 32'h0, 4'h3, 4'h6},
    '{CMD_DR, 6'h20, 32'h0, ID_W, 4'h3, 4'h6},
    '{CMD_IR, 6'h04, 32'(OP_BYPASS), IRC, 4'h3, 4'h6},
    '{CMD_DR, 6'h08, 32'hA5, 32'h4A, 4'h3, 4'h6},
    '{CMD_IR, 6'h04, 32'(OP_SAMPLE), IRC, 4'h3, 4'h6},
    '{CMD_DR, 6'h08, 32'h88, 32'h1B, 4'h3, 4'h6},
    '{CMD_IR, 6'h04, 32'(OP_EXTEST), IRC, 4'hA, 4'h0},
    '{CMD_IR, 6'h04, 32'(OP_CLAMP), IRC, 4'hA, 4'h0},
    '{CMD_DR, 6'h08, 32'hA5, 32'h4A, 4'hA, 4'h0},
    '{CMD_IR, 6'h04, 32'(OP_HIGHZ), IRC, 4'h3, 4'hF},
    '{CMD_DR, 6'h01, 32'h1, 32'h0, 4'h3, 4'hF},
    '{CMD_IR, 6'h04, 32'h7, IRC, 4'h3, 4'h6},
    '{CMD_DR, 6'h04, 32'h5, 32'hA, 4'h3, 4'h6},
    '{CMD_IR, 6'h04, 32'(OP_IDCODE), IRC, 4'h3, 4'h6},
    '{CMD_DR, 6'h20, 32'h0, ID_W, 4'h3, 4'h6}
  };

  logic              core_clk;
  logic              resetn;
  logic              cmd_valid;
  logic              cmd_ready;
  cmd_kind_t         cmd_kind;
  logic [LEN_W-1:0]  cmd_len;
  logic [WORD_W-1:0] cmd_data;
  logic              res_valid;
  logic              res_ready;
  logic [WORD_W-1:0] res_data;
  logic [N_PINS-1:0] core_out;
  logic [N_PINS-1:0] core_oe_n;
  logic [N_PINS-1:0] pin_in;
  logic [N_PINS-1:0] pin_out;
  logic [N_PINS-1:0] pin_oe_n;
  int                err_total;
  int                n_checks;

  tap_if link ();
  tap_host u_tap_host (.core_clk, .resetn, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_len,
    .cmd_data, .res_valid, .res_ready, .res_data, .tap(link));
  tap_device #(.ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MAKER(ID_M)) u_tap_device (.core_clk,
    .resetn, .tap(link), .core_out, .core_oe_n, .pin_in, .pin_out, .pin_oe_n);
  tap_checker u_tap_checker (.core_clk, .resetn, .tck(link.tck), .tms(link.tms),
    .tdi(link.tdi), .tdo(link.tdo), .tdo_oe_n(link.tdo_oe_n));

  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // bounded wait for ready (0) or a result (1)
  task automatic await(input bit want_res);
    for (int i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      if (want_res ? res_valid === 1'b1 : cmd_ready === 1'b1) return;
    end
    err_total++;
    $display("MISMATCH wait expected 1 seen 0");
    results();
  endtask : await

  task automatic send(input cmd_kind_t k, input logic [5:0] n, input logic [31:0] d);
    await(1'b0);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_len = n;
    cmd_data = d;
    @(posedge core_clk);
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask : send

  task automatic take(input string what, input logic [31:0] exp);
    await(1'b1);
    check(what, res_data, exp);
    res_ready = 1'b1;
    @(negedge core_clk);
    res_ready = 1'b0;
  endtask : take

  // --------------------------------
  // sequence
  // --------------------------------
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = CMD_RESET;
    cmd_len = 6'h01;
    cmd_data = 32'h0;
    res_ready = 1'b0;
    pin_in = 4'h5;
    core_out = 4'h3;
    core_oe_n = 4'h6;
    err_total = 0;
    n_checks = 0;
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    foreach (rows[i]) begin
      send(rows[i].k, rows[i].n, rows[i].d);
      if (rows[i].k != CMD_RESET) take("scan word", rows[i].r);
      await(1'b0);
      // update lands a few clocks after the host reports done
      repeat (16) @(negedge core_clk);
      check("pin value", 32'(pin_out), 32'(rows[i].po));
      check("pin enable", 32'(pin_oe_n), 32'(rows[i].pe));
      $display("row %0d done", i);
    end
    // buffer fills behind passthrough scans and refuses further commands
    send(CMD_IR, 6'h04, 32'(OP_BYPASS));
    take("ir capture", IRC);
    for (int j = 0; j < FIFO_DEPTH; j++) send(CMD_DR, 6'h08, 32'(j * 3 + 1));
    for (int j = 0; j < 1000; j++) begin
      @(negedge core_clk);
      if (cmd_ready !== 1'b0) break;
    end
    check("full refuses", 32'(cmd_ready), 32'h0);
    for (int j = 0; j < FIFO_DEPTH; j++) take("buffer order", 32'((j * 3 + 1) * 2));
    check("drained", 32'(res_valid), 32'h0);
    $display("buffer test done");
    // five mode highs must restore the identity instruction
    send(CMD_RESET, 6'h00, 32'h0);
    send(CMD_DR, 6'h20, 32'h0);
    take("identity after tms reset", ID_W);
    $display("tms reset test done");
    // reset in the middle of a scan
    send(CMD_DR, 6'h20, 32'h0);
    repeat (100) @(negedge core_clk);
    resetn = 1'b0;
    @(negedge core_clk);
    check("reset tdo enable", 32'(link.tdo_oe_n), 32'h1);
    check("reset tms", 32'(link.tms), 32'h1);
    check("reset pins", 32'(pin_oe_n), 32'hF);
    check("reset result", 32'(res_valid), 32'h0);
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    // scans assume run-test/idle, so walk the port out of test reset first
    send(CMD_RESET, 6'h00, 32'h0);
    send(CMD_DR, 6'h20, 32'h0);
    take("identity after reset", ID_W);
    $display("mid-scan reset test done");
    results();
  end
endmodule : tb_top
